// [rpc_config_bank.sv]
// Receive-port control channel configuration register bank
`timescale 1ns/100ps
`default_nettype none
module rpc_config_bank
  import rpc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic [2:0] rate_strap,
  input  wire rpc_req_t   req,
  output logic [7:0]      rdata,
  output logic            rvalid,
  input  wire rpc_load_t  load,
  input  wire logic       rate_settled,
  input  wire logic [6:0] target_addr,
  input  wire rpc_txn_t   txn,
  output rpc_route_t      route,
  output logic            return_link_en,
  output logic            return_link_checksum_gen_on,
  output logic [2:0]      return_link_rate_sel,
  output logic            return_link_rate_ok,
  output logic [1:0]      return_link_rate_idx,
  output logic [1:0]      downstream_pin_count,
  output logic [6:0]      remote_transmitter_id,
  output logic            rate_auto_ack
);

  logic       fwd_all_r;
  logic       fwd_match_r;
  logic       local_ack_r;
  logic       return_link_force_on_r;
  logic       checksum_r;
  logic [2:0] rate_r;
  logic       strap_taken_r;
  logic       keep_local_path_settings_r;
  logic [1:0] pin_count_r;
  logic [6:0] ident_r;
  logic       lock_remote_id_r;
  logic [6:0] alias_r;
  logic       self_ack_r;
  logic       rate_auto_ack_r;
  logic       wr_cc;
  logic       wr_dp;
  logic       wr_id;
  logic       wr_al;
  logic [7:0] rdata_nxt;

  assign wr_cc = req.wr && (req.addr == RPC_OFS_CC_CONFIG);
  assign wr_dp = req.wr && (req.addr == RPC_OFS_DATAPATH_ONE);
  assign wr_id = req.wr && (req.addr == RPC_OFS_REMOTE_IDENT);
  assign wr_al = req.wr && (req.addr == RPC_OFS_REMOTE_ALIAS);

  // Forwarding, acknowledge and checksum controls
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fwd_all_r   <= RPC_RST_CC_HI[RPC_BIT_FWD_ALL];
      fwd_match_r <= RPC_RST_CC_HI[RPC_BIT_FWD_MATCH];
      local_ack_r <= RPC_RST_CC_HI[RPC_BIT_LOCAL_ACK];
      checksum_r  <= RPC_RST_CC_HI[RPC_BIT_CHECKSUM];
    end else if (wr_cc) begin
      fwd_all_r   <= req.wdata[RPC_BIT_FWD_ALL];
      fwd_match_r <= req.wdata[RPC_BIT_FWD_MATCH];
      local_ack_r <= req.wdata[RPC_BIT_LOCAL_ACK];
      checksum_r  <= req.wdata[RPC_BIT_CHECKSUM];
    end
  end

  // Force-on bit: local writes only
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      return_link_force_on_r <= RPC_RST_CC_HI[RPC_BIT_FORCE_ON];
    end else if (wr_cc && !req.remote) begin
      return_link_force_on_r <= req.wdata[RPC_BIT_FORCE_ON];
    end
  end

  // Rate field: strap caught on the first edge after reset release
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rate_r        <= RPC_RATE_2M5;
      strap_taken_r <= 1'b0;
    end else if (!strap_taken_r) begin
      rate_r        <= rate_strap;
      strap_taken_r <= 1'b1;
    end else if (wr_cc) begin
      rate_r <= req.wdata[RPC_RATE_MSB:0];
    end
  end

  // Auto-acknowledge while a remotely requested rate change settles
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rate_auto_ack_r <= 1'b0;
    end else if (wr_cc && req.remote && (req.wdata[RPC_RATE_MSB:0] != rate_r)) begin
      rate_auto_ack_r <= 1'b1;
    end else if (rate_settled) begin
      rate_auto_ack_r <= 1'b0;
    end
  end

  // Datapath control: keep-local bit and pin count
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      keep_local_path_settings_r <= RPC_RST_DATAPATH[RPC_BIT_KEEP_LOCAL];
      pin_count_r                <= RPC_RST_DATAPATH[RPC_PIN_CNT_MSB:0];
    end else begin
      if (wr_dp) begin
        keep_local_path_settings_r <= req.wdata[RPC_BIT_KEEP_LOCAL];
      end
      if (wr_dp && req.wdata[RPC_BIT_KEEP_LOCAL]) begin
        pin_count_r <= req.wdata[RPC_PIN_CNT_MSB:0];
      end else if (load.pins_valid && !keep_local_path_settings_r) begin
        pin_count_r <= load.pins;
      end
    end
  end

  // Remote transmitter identity and lock
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ident_r          <= RPC_RST_IDENT[7:1];
      lock_remote_id_r <= RPC_RST_IDENT[RPC_BIT_LOCK_ID];
    end else if (wr_id) begin
      ident_r          <= req.wdata[7:1];
      lock_remote_id_r <= req.wdata[RPC_BIT_LOCK_ID];
    end else if (load.id_valid && !lock_remote_id_r) begin
      ident_r <= load.id;
    end
  end

  // Alias and remote self-acknowledge
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      alias_r    <= RPC_RST_ALIAS[7:1];
      self_ack_r <= RPC_RST_ALIAS[RPC_BIT_SELF_ACK];
    end else if (wr_al) begin
      alias_r    <= req.wdata[7:1];
      self_ack_r <= req.wdata[RPC_BIT_SELF_ACK];
    end
  end

  // Read mux
  always_comb begin
    rdata_nxt = 8'h00;
    unique case (req.addr)
      RPC_OFS_CC_CONFIG:    rdata_nxt = {fwd_all_r, fwd_match_r, local_ack_r, return_link_force_on_r,
                                         checksum_r, rate_r};
      RPC_OFS_DATAPATH_ONE: rdata_nxt = {keep_local_path_settings_r, 5'h00, pin_count_r} & RPC_DATAPATH_WMASK;
      RPC_OFS_REMOTE_IDENT: rdata_nxt = {ident_r, lock_remote_id_r};
      RPC_OFS_REMOTE_ALIAS: rdata_nxt = {alias_r, self_ack_r};
      default:              rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdata  <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      if (req.rd) begin
        rdata <= rdata_nxt;
      end
    end
  end

  assign return_link_en              = return_link_force_on_r || fwd_all_r || fwd_match_r;
  assign return_link_checksum_gen_on = checksum_r;
  assign return_link_rate_sel        = rate_r;
  assign downstream_pin_count        = pin_count_r;
  assign remote_transmitter_id       = ident_r;
  assign rate_auto_ack               = rate_auto_ack_r;

  rpc_rate_decode u_rate (
    .rate_code  (rate_r),
    .rate_valid (return_link_rate_ok),
    .rate_index (return_link_rate_idx)
  );

  rpc_route u_route (
    .fwd_all         (fwd_all_r),
    .fwd_match       (fwd_match_r),
    .local_ack       (local_ack_r),
    .auto_ack_rate   (rate_auto_ack_r),
    .alias_addr      (alias_r),
    .self_ack_remote (self_ack_r),
    .target_addr     (target_addr),
    .txn             (txn),
    .route           (route)
  );

  // Checks
  sequence s_remote_force_wr;
    wr_cc && req.remote && (req.wdata[RPC_BIT_FORCE_ON] != return_link_force_on_r);
  endsequence

  AST_FORCE_ON_RESET: assert property (@(posedge mclk) $rose(arst_n) |-> return_link_force_on_r)
    else $error("force-on not set after reset");
  AST_LINK_EN: assert property (@(posedge mclk) disable iff (!arst_n)
    (!return_link_force_on_r && !fwd_all_r && !fwd_match_r) |-> !return_link_en)
    else $error("return link enabled without cause");
  AST_REMOTE_FORCE_IGNORED: assert property (@(posedge mclk) disable iff (!arst_n)
    s_remote_force_wr |=> $stable(return_link_force_on_r))
    else $error("remote write changed force-on");
  AST_FORWARD_ALL: assert property (@(posedge mclk) disable iff (!arst_n)
    (txn.valid && fwd_all_r) |-> route.forward)
    else $error("transaction not forwarded with forward-all");
  AST_NO_FORWARD: assert property (@(posedge mclk) disable iff (!arst_n)
    (!fwd_all_r && !fwd_match_r) |-> !route.forward)
    else $error("forwarded while forwarding disabled");
  AST_LOCAL_ACK: assert property (@(posedge mclk) disable iff (!arst_n)
    (txn.valid && txn.is_write && local_ack_r) |-> route.self_ack)
    else $error("write not self-acknowledged");
  AST_RATE_AUTO_ACK: assert property (@(posedge mclk) disable iff (!arst_n)
    (wr_cc && req.remote && (req.wdata[2:0] != rate_r)) |=> rate_auto_ack_r)
    else $error("no auto-ack on remote rate change");
  AST_KEEP_LOCAL: assert property (@(posedge mclk) disable iff (!arst_n)
    (keep_local_path_settings_r && !wr_dp) |=> $stable(pin_count_r))
    else $error("pin count loaded while kept local");
  AST_ID_LOCK: assert property (@(posedge mclk) disable iff (!arst_n)
    (lock_remote_id_r && !wr_id) |=> $stable(ident_r))
    else $error("identity loaded while locked");
  AST_ID_LOAD: assert property (@(posedge mclk) disable iff (!arst_n)
    (load.id_valid && !lock_remote_id_r && !wr_id) |=> (ident_r == $past(load.id)))
    else $error("identity not loaded");
  AST_ALIAS_ZERO: assert property (@(posedge mclk) disable iff (!arst_n)
    (alias_r == 7'h00) |-> !route.alias_hit)
    else $error("alias zero matched");
  AST_REMAP: assert property (@(posedge mclk) disable iff (!arst_n)
    route.alias_hit |-> (route.remap_addr == target_addr))
    else $error("alias hit not remapped");
  AST_RESERVED_ZERO: assert property (@(posedge mclk) disable iff (!arst_n)
    (rvalid && $past(req.addr) == RPC_OFS_DATAPATH_ONE) |-> (rdata[6:2] == 5'h00))
    else $error("reserved bits nonzero");
  AST_REMOTE_SELF_ACK: assert property (@(posedge mclk) disable iff (!arst_n)
    (txn.is_write && route.alias_hit && self_ack_r) |-> route.self_ack)
    else $error("remote write not self-acknowledged");
  AST_PIN_LOAD: assert property (@(posedge mclk) disable iff (!arst_n)
    (load.pins_valid && !keep_local_path_settings_r && !wr_dp) |=> (pin_count_r == $past(load.pins)))
    else $error("pin count not loaded");
  AST_RATE_STRAP: assert property (@(posedge mclk)
    $rose(arst_n) |=> (rate_r == $past(rate_strap)))
    else $error("rate not taken from strap");

endmodule : rpc_config_bank
`default_nettype wire

// [rpc_pkg.sv]
// Package for the receive-port control channel configuration bank
package rpc_pkg;

  // Register offsets on the local register port
  localparam logic [7:0] RPC_OFS_CC_CONFIG     = 8'h58;
  localparam logic [7:0] RPC_OFS_DATAPATH_ONE  = 8'h59;
  localparam logic [7:0] RPC_OFS_REMOTE_IDENT  = 8'h5b;
  localparam logic [7:0] RPC_OFS_REMOTE_ALIAS  = 8'h5c;

  // Field positions, control channel configuration
  localparam int RPC_BIT_FWD_ALL    = 7;
  localparam int RPC_BIT_FWD_MATCH  = 6;
  localparam int RPC_BIT_LOCAL_ACK  = 5;
  localparam int RPC_BIT_FORCE_ON   = 4;
  localparam int RPC_BIT_CHECKSUM   = 3;
  localparam int RPC_RATE_MSB       = 2;

  // Field positions, datapath control and identity registers
  localparam int RPC_BIT_KEEP_LOCAL = 7;
  localparam int RPC_PIN_CNT_MSB    = 1;
  localparam int RPC_BIT_LOCK_ID    = 0;
  localparam int RPC_BIT_SELF_ACK   = 0;

  // Values after reset, and datapath readback mask
  localparam logic [7:0] RPC_RST_CC_HI       = 8'h18;
  localparam logic [7:0] RPC_RST_DATAPATH    = 8'h00;
  localparam logic [7:0] RPC_RST_IDENT       = 8'h00;
  localparam logic [7:0] RPC_RST_ALIAS       = 8'h00;
  localparam logic [7:0] RPC_DATAPATH_WMASK  = 8'h83;

  // Return-link rate codes
  localparam logic [2:0] RPC_RATE_2M5 = 3'h0;
  localparam logic [2:0] RPC_RATE_10M = 3'h2;
  localparam logic [2:0] RPC_RATE_50M = 3'h6;

  // Downstream pin count codes
  localparam logic [1:0] RPC_PINS_NONE = 2'h0;
  localparam logic [1:0] RPC_PINS_ONE  = 2'h1;
  localparam logic [1:0] RPC_PINS_TWO  = 2'h2;
  localparam logic [1:0] RPC_PINS_FOUR = 2'h3;

  // Register read/write request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       remote;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rpc_req_t;

  // Forward-channel load request
  typedef struct packed {
    logic       id_valid;
    logic [6:0] id;
    logic       pins_valid;
    logic [1:0] pins;
  } rpc_load_t;

  // Local transaction to be steered
  typedef struct packed {
    logic       valid;
    logic       is_write;
    logic [6:0] addr;
    logic       match;
  } rpc_txn_t;

  // Steering decision
  typedef struct packed {
    logic       forward;
    logic       alias_hit;
    logic [6:0] remap_addr;
    logic       self_ack;
  } rpc_route_t;

endpackage : rpc_pkg

// [rpc_rate_decode.sv]
// Return-link rate decode
`timescale 1ns/100ps
`default_nettype none
module rpc_rate_decode
  import rpc_pkg::*;
(
  input  wire logic [2:0] rate_code,
  output logic            rate_valid,
  output logic [1:0]      rate_index
);

  always_comb begin
    rate_valid = 1'b1;
    rate_index = 2'h0;
    unique case (rate_code)
      RPC_RATE_2M5: rate_index = 2'h0;
      RPC_RATE_10M: rate_index = 2'h1;
      RPC_RATE_50M: rate_index = 2'h2;
      default: begin
        rate_valid = 1'b0;
        rate_index = 2'h3;
      end
    endcase
  end

endmodule : rpc_rate_decode
`default_nettype wire

// [rpc_route.sv]
// Local transaction steering: forwarding, alias decode and self-acknowledge
`timescale 1ns/100ps
`default_nettype none
module rpc_route
  import rpc_pkg::*;
(
  input  wire logic       fwd_all,
  input  wire logic       fwd_match,
  input  wire logic       local_ack,
  input  wire logic       auto_ack_rate,
  input  wire logic [6:0] alias_addr,
  input  wire logic       self_ack_remote,
  input  wire logic [6:0] target_addr,
  input  wire rpc_txn_t   txn,
  output rpc_route_t      route
);

  logic alias_hit;

  // Zero alias never matches
  assign alias_hit = txn.valid && (alias_addr != 7'h00) && (txn.addr == alias_addr);

  always_comb begin
    route.alias_hit  = alias_hit;
    route.remap_addr = alias_hit ? target_addr : txn.addr;
    route.forward    = txn.valid && (fwd_all || (fwd_match && (txn.match || alias_hit)));
    route.self_ack   = txn.valid && txn.is_write &&
                       (local_ack || auto_ack_rate || (self_ack_remote && alias_hit));
  end

endmodule : rpc_route
`default_nettype wire

// [rpc_ser_model.sv]
// Far-side model: forward-channel loads and return-link settle answer
`timescale 1ns/100ps
`default_nettype none
module rpc_ser_model
  import rpc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       id_send,
  input  wire logic [6:0] id_val,
  input  wire logic       pins_send,
  input  wire logic [1:0] pins_val,
  input  wire logic [3:0] settle_dly,
  input  wire logic       rate_auto_ack,
  output rpc_load_t       load,
  output logic            rate_settled
);
  logic [3:0] cnt_r;

  // Outside a valid pulse the payload is stale, so show its inverse
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      load <= '0;
    end else begin
      load.id_valid   <= id_send;
      load.id         <= id_send ? id_val : ~load.id;
      load.pins_valid <= pins_send;
      load.pins       <= pins_send ? pins_val : ~load.pins;
    end
  end

  // Link answers again only after settle_dly cycles at the new rate
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r        <= 4'h0;
      rate_settled <= 1'b0;
    end else begin
      rate_settled <= rate_auto_ack && (cnt_r == settle_dly);
      cnt_r        <= (rate_auto_ack && (cnt_r != settle_dly)) ? cnt_r + 4'h1 : 4'h0;
    end
  end
endmodule // rpc_ser_model
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the control channel configuration bank
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import rpc_pkg::*;
;
  localparam logic [2:0]  STRAP = 3'h6;
  localparam logic [23:0] ROWS [6] = '{24'h59ff83, 24'h597c03, 24'h5babab,
                                       24'h5c5555, 24'h58e7e7, 24'h40ff00};
  logic       mclk, arst_n, rvalid, ret_en, cks_on, rate_ok, auto_ack;
  logic       id_send, pins_send, rate_settled;
  logic [7:0] rdata;
  logic [6:0] id_val, target, rtx_id;
  logic [3:0] settle_dly;
  logic [2:0] rate_sel, rc;
  logic [1:0] pins_val, rate_idx, pins, ix;
  rpc_req_t   req;
  rpc_txn_t   txn;
  rpc_route_t route;
  rpc_load_t  load;
  int         num_errors, samples_checked, cycles, i;

  rpc_config_bank u_dut (.mclk(mclk), .arst_n(arst_n), .rate_strap(STRAP), .req(req), .rdata(rdata),
    .rvalid(rvalid), .load(load), .rate_settled(rate_settled), .target_addr(target), .txn(txn),
    .route(route), .return_link_en(ret_en), .return_link_checksum_gen_on(cks_on),
    .return_link_rate_sel(rate_sel), .return_link_rate_ok(rate_ok), .return_link_rate_idx(rate_idx),
    .downstream_pin_count(pins), .remote_transmitter_id(rtx_id), .rate_auto_ack(auto_ack));

  rpc_ser_model u_ser (.mclk(mclk), .arst_n(arst_n), .id_send(id_send), .id_val(id_val),
    .pins_send(pins_send), .pins_val(pins_val), .settle_dly(settle_dly),
    .rate_auto_ack(auto_ack), .load(load), .rate_settled(rate_settled));

  always #5 mclk = ~mclk;

  task automatic complete_run();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One port copy only, so the port is always selected
  task automatic acc(input logic w, input logic rem, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    req = '{wr: w, rd: !w, remote: rem, addr: a, wdata: d};
    @(posedge mclk);
    #1;
    req.wr = 1'b0;
    req.rd = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    acc(1'b0, 1'b0, a, 8'h00);
    chk({7'h00, rvalid}, 8'h01);
    chk(rdata, exp);
  endtask

  task automatic fc(input logic is_id, input logic [6:0] v);
    @(posedge mclk);
    #1;
    id_send   = is_id;
    pins_send = !is_id;
    id_val    = v;
    pins_val  = v[1:0];
    @(posedge mclk);
    #1;
    id_send   = 1'b0;
    pins_send = 1'b0;
    @(posedge mclk);
    #1;
  endtask

  task automatic steer(input logic [6:0] a, input logic m, input logic [2:0] exp);
    @(posedge mclk);
    #1;
    txn = '{valid: 1'b1, is_write: 1'b1, addr: a, match: m};
    #1;
    chk({5'h00, route.forward, route.alias_hit, route.self_ack}, {5'h00, exp});
  endtask

  initial begin
    mclk = 0;
    arst_n = 0;
    req = '0;
    txn = '0;
    id_send = 0;
    pins_send = 0;
    id_val = 7'h00;
    pins_val = 2'h0;
    settle_dly = 4'h4;
    target = 7'h3c;
    num_errors = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (10) @(posedge mclk);
    #1;
    arst_n = 1;
    rd(RPC_OFS_CC_CONFIG, RPC_RST_CC_HI | {5'h00, STRAP});
    rd(RPC_OFS_DATAPATH_ONE, RPC_RST_DATAPATH);
    rd(RPC_OFS_REMOTE_IDENT, RPC_RST_IDENT);
    rd(RPC_OFS_REMOTE_ALIAS, RPC_RST_ALIAS);
    chk({6'h00, ret_en, cks_on}, 8'h03);
    for (i = 0; i < 6; i++) begin
      acc(1'b1, 1'b0, ROWS[i][23:16], ROWS[i][15:8]);
      rd(ROWS[i][23:16], ROWS[i][7:0]);
    end
    for (i = 0; i < 8; i++) begin
      rc = i[2:0];
      ix = (rc == RPC_RATE_2M5) ? 2'h0 : (rc == RPC_RATE_10M) ? 2'h1 : (rc == RPC_RATE_50M) ? 2'h2 : 2'h3;
      acc(1'b1, 1'b0, RPC_OFS_CC_CONFIG, {5'h03, rc});
      chk({2'h0, rate_sel, rate_ok, rate_idx}, {2'h0, rc, ix != 2'h3, ix});
    end
    acc(1'b1, 1'b0, RPC_OFS_CC_CONFIG, 8'h16);
    chk({7'h00, cks_on}, 8'h00);
    acc(1'b1, 1'b1, RPC_OFS_CC_CONFIG, 8'h02);
    chk({7'h00, auto_ack}, 8'h01);
    steer(7'h11, 1'b0, 3'h1);
    rd(RPC_OFS_CC_CONFIG, 8'h12);
    i = 0;
    while (auto_ack && i < 20) begin
      @(posedge mclk);
      #1;
      i++;
    end
    chk({auto_ack, 6'h00, i > 2}, 8'h01);
    for (i = 0; i < 4; i++) begin
      acc(1'b1, 1'b0, RPC_OFS_CC_CONFIG, {i[1:0], 6'h02});
      chk({7'h00, ret_en}, {7'h00, i != 0});
      steer(7'h11, 1'b0, {i[1], 2'h0});
      steer(7'h11, 1'b1, {i != 0, 2'h0});
    end
    acc(1'b1, 1'b0, RPC_OFS_CC_CONFIG, 8'h42);
    steer(7'h2a, 1'b0, 3'h7);
    chk({1'b0, route.remap_addr}, {1'b0, target});
    acc(1'b1, 1'b0, RPC_OFS_REMOTE_ALIAS, 8'h01);
    steer(7'h00, 1'b0, 3'h0);
    acc(1'b1, 1'b0, RPC_OFS_CC_CONFIG, 8'h22);
    steer(7'h11, 1'b0, 3'h1);
    fc(1'b1, 7'h12);
    chk({1'b0, rtx_id}, 8'h55);
    acc(1'b1, 1'b0, RPC_OFS_REMOTE_IDENT, 8'h00);
    fc(1'b1, 7'h12);
    rd(RPC_OFS_REMOTE_IDENT, 8'h24);
    fc(1'b0, 7'h01);
    chk({6'h00, pins}, 8'h01);
    acc(1'b1, 1'b0, RPC_OFS_DATAPATH_ONE, 8'h82);
    fc(1'b0, 7'h01);
    rd(RPC_OFS_DATAPATH_ONE, 8'h82);
    // Mid-run reset with force-on and checksum cleared beforehand
    arst_n = 0;
    repeat (2) @(posedge mclk);
    #1;
    arst_n = 1;
    rd(RPC_OFS_CC_CONFIG, RPC_RST_CC_HI | {5'h00, STRAP});
    chk({6'h00, ret_en, cks_on}, 8'h03);
    rd(RPC_OFS_DATAPATH_ONE, RPC_RST_DATAPATH);
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
